// ---- design/cpc_pkg.sv ----
// package: register map, field layout and constants for the capture/pwm channel
// Notes on behaviour
// - four capture prescaler settings via mode field
// - prescaler counter cleared when off or not capture
// - prescaler change alone keeps counter running
// - instruction-clock timebase holds during sleep
// - external-clock timebase keeps capturing in sleep
// - period is (period+1)*4*tosc*prescale
// - period match clears timebase, sets pin unless duty zero, latches duty
// - duty is low byte plus two control bits
// - new duty applies only at period match
// - duty high buffer read-only in pwm mode
// - pulse width is duty*tosc*prescale
// - capture on fall, rise, 4th or 16th rise
// - capture copies timebase, sets flag, overwrites
// - 10-bit base compare with latched duty clears pin
package cpc_pkg;
	localparam logic [7:0] CPC_ADDR_CTRL = 8'h00;
	localparam logic [7:0] CPC_ADDR_DUTY_LOW = 8'h04;
	localparam logic [7:0] CPC_ADDR_DUTY_HIGH = 8'h08;
	localparam logic [7:0] CPC_ADDR_PERIOD = 8'h0C;
	localparam logic [7:0] CPC_ADDR_TIMER = 8'h10;
	localparam logic [7:0] CPC_ADDR_STATUS = 8'h14;
	localparam logic [7:0] CPC_ADDR_MASK = 8'h18;
	localparam logic [7:0] CPC_ADDR_CAP_CFG = 8'h1C;
	localparam logic [7:0] CPC_CTRL_RESET = 8'h00;
	localparam logic [7:0] CPC_PERIOD_RESET = 8'hFF;
	localparam int CPC_MODE_LSB = 0;
	localparam int CPC_DLOW_LSB = 4;
	localparam logic [3:0] CPC_MODE_OFF = 4'h0;
	localparam logic [3:0] CPC_MODE_CAP_FALL = 4'h4;
	localparam logic [3:0] CPC_MODE_CAP_RISE = 4'h5;
	localparam logic [3:0] CPC_MODE_CAP_RISE4 = 4'h6;
	localparam logic [3:0] CPC_MODE_CAP_RISE16 = 4'h7;
	localparam logic [1:0] CPC_MODE_PWM_TOP = 2'h3;
	localparam logic [3:0] CPC_PS_LAST_4 = 4'h3;
	localparam logic [3:0] CPC_PS_LAST_16 = 4'hF;
	localparam int CPC_IRQ_CAPTURE = 0;
	localparam int CPC_IRQ_PERIOD = 1;
	localparam int CPC_PWM_TIMEBASE_COUNT_PS_1 = 0;
	localparam int CPC_PWM_TIMEBASE_COUNT_PS_4 = 1;
	localparam int CPC_PWM_TIMEBASE_COUNT_PS_16 = 2;
	typedef struct packed {
		logic [1:0] duty_low_bits;
		logic [3:0] channel_mode_field;
	} cpc_ctrl_type;
	typedef struct packed {
		logic ext_clock;
		logic [1:0] pwm_prescale;
	} cpc_cfg_type;
endpackage

// ---- design/cpc_sync_edge.sv ----
// pin edge detector on an already-synchronous input
`timescale 1ns/1ps
`default_nettype none
module cpc_sync_edge
	import cpc_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// pin sample and edges
	input wire logic pin_in,
	output logic rise,
	output logic fall
);
	logic prev_r;
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			prev_r <= 1'b0;
		else
			prev_r <= pin_in;
	end
	assign rise = pin_in & ~prev_r;
	assign fall = ~pin_in & prev_r;
endmodule
`default_nettype wire

// ---- design/cpc_channel.sv ----
// top: one capture/pwm channel with apb registers, capture and pwm timebases
//
// The APB slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module cpc_channel
	import cpc_pkg::*;
(
	// clock and reset
	input wire logic CLOCK,
	input wire logic RESET_N,
	// apb slave
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// system state and capture timebase clock
	input wire logic SLEEP,
	input wire logic EXT_TICK,
	// channel pin
	input wire logic CHANNEL_PIN_IN,
	output logic CHANNEL_PIN_OUT,
	output logic CHANNEL_PIN_OE_N,
	// interrupt
	output logic IRQ
);
	logic rst_meta_r, rst_n;
	cpc_ctrl_type ctrl_r;
	cpc_cfg_type cfg_r;
	logic [7:0] duty_low_byte_r, duty_high_buffer_r, pwm_period_reg_r;
	logic [1:0] duty_latch_lo_r;
	logic [7:0] cap_low_r;
	logic [15:0] capture_timebase_count_r;
	logic [7:0] pwm_timebase_count_r;
	logic [1:0] phase_r;
	logic [3:0] tick_div_r;
	logic [3:0] ps_count_r;
	logic [1:0] status_r, mask_r;
	logic pin_r, oe_n_r, irq_r;
	logic [31:0] prdata_r;
	logic pready_r;
	logic pslverr_r;
	logic rise, fall, cap_mode, pwm_mode, cap_evt, inst_tick, t2_step, t2_match, pwm_wrap;
	logic [3:0] tick_div_nxt;
	logic [7:0] pwm_timebase_count_nxt;
	logic [9:0] base10, duty10;
	logic wr_go, rd_go, addr_ok;
	// reset release through two flops
	always_ff @(posedge CLOCK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			rst_meta_r <= 1'b0;
			rst_n <= 1'b0;
		end
		else
		begin
			rst_meta_r <= 1'b1;
			rst_n <= rst_meta_r;
		end
	end
	assign cap_mode = (ctrl_r.channel_mode_field[3:2] == 2'h1);
	assign pwm_mode = (ctrl_r.channel_mode_field[3:2] == CPC_MODE_PWM_TOP);
	// access phase acted on in its first cycle; ready answers after one wait state
	assign wr_go = PSEL & PENABLE & PWRITE & ~pready_r;
	assign rd_go = PSEL & PENABLE & ~PWRITE & ~pready_r;
	always_comb
	begin
		unique case (PADDR)
			CPC_ADDR_CTRL, CPC_ADDR_DUTY_LOW, CPC_ADDR_DUTY_HIGH, CPC_ADDR_PERIOD,
			CPC_ADDR_TIMER, CPC_ADDR_STATUS, CPC_ADDR_MASK, CPC_ADDR_CAP_CFG: addr_ok = 1'b1;
			default: addr_ok = 1'b0;
		endcase
	end
	cpc_sync_edge u_edge (
		.clk(CLOCK),
		.rst_n(rst_n),
		.pin_in(CHANNEL_PIN_IN),
		.rise(rise),
		.fall(fall)
	);
	// instruction clock: one pulse every four system clocks
	always_ff @(posedge CLOCK or negedge rst_n)
	begin
		if (!rst_n)
			phase_r <= 2'h0;
		else
			phase_r <= phase_r + 2'h1;
	end
	assign inst_tick = (phase_r == 2'h3);
	// capture timebase; instruction clock freezes in sleep, external tick does not
	always_ff @(posedge CLOCK or negedge rst_n)
	begin
		if (!rst_n)
			capture_timebase_count_r <= 16'h0000;
		else if (cfg_r.ext_clock ? EXT_TICK : (inst_tick & ~SLEEP))
			capture_timebase_count_r <= capture_timebase_count_r + 16'h0001;
	end
	// capture event selection and prescaler counter
	always_comb
	begin
		cap_evt = 1'b0;
		unique case (ctrl_r.channel_mode_field)
			CPC_MODE_CAP_FALL: cap_evt = fall;
			CPC_MODE_CAP_RISE: cap_evt = rise;
			CPC_MODE_CAP_RISE4: cap_evt = rise & (ps_count_r[1:0] == CPC_PS_LAST_4[1:0]);
			CPC_MODE_CAP_RISE16: cap_evt = rise & (ps_count_r == CPC_PS_LAST_16);
			default: cap_evt = 1'b0;
		endcase
	end
	always_ff @(posedge CLOCK or negedge rst_n)
	begin
		if (!rst_n)
			ps_count_r <= 4'h0;
		else if (!cap_mode)
			ps_count_r <= 4'h0;
		else if (rise)
			ps_count_r <= ps_count_r + 4'h1;
	end
	// pwm timebase: prescale steps, 2-bit sub count extends timer2 to 10 bits
	// step timer2 each 4*tosc*prescale; codes 1 to 3 all mean 1:4
	always_comb
	begin
		unique case (cfg_r.pwm_prescale)
			2'h0: t2_step = (tick_div_r == 4'h3);
			default: t2_step = (tick_div_r == 4'hF);
		endcase
	end
	assign t2_match = (pwm_timebase_count_r == pwm_period_reg_r);
	assign pwm_wrap = t2_step & t2_match;
	always_comb
	begin
		if (!pwm_mode || t2_step)
			tick_div_nxt = 4'h0;
		else
			tick_div_nxt = tick_div_r + 4'h1;
	end
	always_comb
	begin
		if (!pwm_mode || pwm_wrap)
			pwm_timebase_count_nxt = 8'h00;
		else if (t2_step)
			pwm_timebase_count_nxt = pwm_timebase_count_r + 8'h01;
		else
			pwm_timebase_count_nxt = pwm_timebase_count_r;
	end
	// compare the base the next edge will hold, so the pin
	// drops exactly duty steps after it rose, not one clock late
	always_comb
	begin
		unique case (cfg_r.pwm_prescale)
			2'h0: base10 = {pwm_timebase_count_nxt, tick_div_nxt[1:0]};
			default: base10 = {pwm_timebase_count_nxt, tick_div_nxt[3:2]};
		endcase
	end
	assign duty10 = {duty_high_buffer_r, duty_latch_lo_r};
	always_ff @(posedge CLOCK or negedge rst_n)
	begin
		if (!rst_n)
			tick_div_r <= 4'h0;
		else
			tick_div_r <= tick_div_nxt;
	end
	always_ff @(posedge CLOCK or negedge rst_n)
	begin
		if (!rst_n)
			pwm_timebase_count_r <= 8'h00;
		else
			pwm_timebase_count_r <= pwm_timebase_count_nxt;
	end
	// duty double buffer, shared with the captured high byte
	always_ff @(posedge CLOCK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			duty_high_buffer_r <= 8'h00;
			duty_latch_lo_r <= 2'h0;
		end
		else if (pwm_mode && pwm_wrap)
		begin
			duty_high_buffer_r <= duty_low_byte_r;
			duty_latch_lo_r <= ctrl_r.duty_low_bits;
		end
		else if (cap_evt)
			duty_high_buffer_r <= capture_timebase_count_r[15:8];
		else if (wr_go && !pwm_mode && PADDR == CPC_ADDR_DUTY_HIGH)
			duty_high_buffer_r <= PWDATA[7:0];
	end
	// captured low byte kept apart so a duty write cannot spoil it
	always_ff @(posedge CLOCK or negedge rst_n)
	begin
		if (!rst_n)
			cap_low_r <= 8'h00;
		else if (cap_evt)
			cap_low_r <= capture_timebase_count_r[7:0];
	end
	// pwm pin: set at wrap unless zero duty, cleared on base match
	always_ff @(posedge CLOCK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pin_r <= 1'b0;
			oe_n_r <= 1'b1;
		end
		else
		begin
			oe_n_r <= ~pwm_mode;
			if (!pwm_mode)
				pin_r <= 1'b0;
			else if (pwm_wrap)
				pin_r <= ({duty_low_byte_r, ctrl_r.duty_low_bits} != 10'h000);
			else if (base10 == duty10)
				pin_r <= 1'b0;
		end
	end
	// software registers
	always_ff @(posedge CLOCK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ctrl_r <= cpc_ctrl_type'(6'h00);
			cfg_r <= cpc_cfg_type'(3'h0);
			duty_low_byte_r <= 8'h00;
			pwm_period_reg_r <= CPC_PERIOD_RESET;
			mask_r <= 2'h0;
		end
		else if (wr_go)
		begin
			unique case (PADDR)
				CPC_ADDR_CTRL: ctrl_r <= cpc_ctrl_type'(PWDATA[5:0]);
				CPC_ADDR_DUTY_LOW: duty_low_byte_r <= PWDATA[7:0];
				CPC_ADDR_PERIOD: pwm_period_reg_r <= PWDATA[7:0];
				CPC_ADDR_MASK: mask_r <= PWDATA[1:0];
				CPC_ADDR_CAP_CFG: cfg_r <= cpc_cfg_type'(PWDATA[2:0]);
				default: ;
			endcase
		end
	end
	// sticky flags: set wins over write-one-to-clear
	always_ff @(posedge CLOCK or negedge rst_n)
	begin
		if (!rst_n)
			status_r <= 2'h0;
		else
		begin
			for (int i = 0; i < 2; i++)
			begin
				if ((i == CPC_IRQ_CAPTURE && cap_evt) || (i == CPC_IRQ_PERIOD && pwm_wrap))
					status_r[i] <= 1'b1;
				else if (wr_go && PADDR == CPC_ADDR_STATUS && PWDATA[i])
					status_r[i] <= 1'b0;
			end
		end
	end
	// bus answer: one wait cycle, error only on unmapped words
	always_ff @(posedge CLOCK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
		end
		else
		begin
			pready_r <= PSEL & PENABLE & ~pready_r;
			pslverr_r <= PSEL & PENABLE & ~pready_r & ~addr_ok;
		end
	end
	// interrupt level, one cycle behind the flags
	always_ff @(posedge CLOCK or negedge rst_n)
	begin
		if (!rst_n)
			irq_r <= 1'b0;
		else
			irq_r <= |(status_r & mask_r);
	end
	// read data stands only in the ready cycle, zero otherwise
	always_ff @(posedge CLOCK or negedge rst_n)
	begin
		if (!rst_n)
			prdata_r <= 32'h0000_0000;
		else if (rd_go)
		begin
			unique case (PADDR)
				CPC_ADDR_CTRL: prdata_r <= {26'h0, ctrl_r};
				CPC_ADDR_DUTY_LOW: prdata_r <= {24'h0, pwm_mode ? duty_low_byte_r : cap_low_r};
				CPC_ADDR_DUTY_HIGH: prdata_r <= {24'h0, duty_high_buffer_r};
				CPC_ADDR_PERIOD: prdata_r <= {24'h0, pwm_period_reg_r};
				CPC_ADDR_TIMER: prdata_r <= {16'h0, capture_timebase_count_r};
				CPC_ADDR_STATUS: prdata_r <= {30'h0, status_r};
				CPC_ADDR_MASK: prdata_r <= {30'h0, mask_r};
				CPC_ADDR_CAP_CFG: prdata_r <= {29'h0, cfg_r};
				default: prdata_r <= 32'h0000_0000;
			endcase
		end
		else
			prdata_r <= 32'h0000_0000;
	end
	assign PRDATA = prdata_r;
	assign PREADY = pready_r;
	assign PSLVERR = pslverr_r;
	assign CHANNEL_PIN_OUT = pin_r;
	assign CHANNEL_PIN_OE_N = oe_n_r;
	assign IRQ = irq_r;
endmodule
`default_nettype wire

// ---- dv/cpc_channel_props.sv ----
// checker: bus answer and pin drive of the channel
`timescale 1ns/1ps
`default_nettype none
module cpc_channel_props
	import cpc_pkg::*;
(
	// clock, reset, bus, pin
	input wire logic CLOCK,
	input wire logic RESET_N,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PRDATA,
	input wire logic PREADY,
	input wire logic PSLVERR,
	input wire logic CHANNEL_PIN_OUT,
	input wire logic CHANNEL_PIN_OE_N
);
	default clocking @(posedge CLOCK);
	endclocking
	default disable iff (!RESET_N);
	sequence open_s;
		PSEL && PENABLE && !PREADY;
	endsequence
	wait_one_a: assert property (open_s |=> PREADY)
		else $error("access not answered after one wait");
	ready_pulse_a: assert property (PREADY |=> !PREADY)
		else $error("ready held over one cycle");
	ready_cause_a: assert property (PREADY |-> $past(PSEL && PENABLE))
		else $error("ready without access");
	err_ready_a: assert property (PSLVERR |-> PREADY)
		else $error("error outside answer");
	rdata_idle_a: assert property (!PREADY |-> PRDATA == 32'h0)
		else $error("read data outside answer");
	rdata_upper_a: assert property (PREADY |-> PRDATA[31:16] == 16'h0)
		else $error("upper read data not zero");
	mapped_ok_a: assert property (PREADY && PADDR[7:5] == 3'h0 && PADDR[1:0] == 2'h0 |-> !PSLVERR)
		else $error("error on mapped address");
	pin_pwm_a: assert property ($rose(CHANNEL_PIN_OUT) |-> !CHANNEL_PIN_OE_N)
		else $error("pin set while not driven");
endmodule
bind cpc_channel cpc_channel_props u_props (.CLOCK, .RESET_N, .PSEL, .PENABLE, .PADDR,
	.PRDATA, .PREADY, .PSLVERR, .CHANNEL_PIN_OUT, .CHANNEL_PIN_OE_N);
`default_nettype wire

// ---- dv/cpc_pin_partner.sv ----
// pin partner: source on the channel pin and external timebase ticks
`timescale 1ns/1ps
`default_nettype none
module cpc_pin_partner
(
	// from the bench
	input wire logic clk,
	input wire logic level,
	input wire logic tick_on,
	// pin side
	input wire logic pin_out,
	input wire logic pin_oe_n,
	output logic pin_in,
	output logic ext_tick
);
	logic [1:0] div_r = 2'h0;
	// the source yields the wire while the channel drives it
	assign pin_in = pin_oe_n ? level : pin_out;
	always_ff @(posedge clk)
	begin
		div_r <= div_r + 2'h1;
	end
	// ticks well below the system clock rate
	assign ext_tick = tick_on && div_r == 2'h0;
endmodule
`default_nettype wire

// ---- dv/cpc_channel_test.sv ----
// testbench: register level tests of the capture/pwm channel
`timescale 1ns/1ps
`default_nettype none
module cpc_channel_test
	import cpc_pkg::*;
;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic sleep = 1'b0;
	logic level = 1'b0;
	logic tick_on = 1'b0;
	logic [31:0] prdata, rd, t;
	logic pready, pslverr, err, ext_tick, pin_in, pin_out, oe_n, irq, pin_d;
	int num_errors, check_count, spin, cnt, t_rise, hi_len, per_len, rises, r, m;
	int need[4] = '{1, 1, 4, 16};
	always #4 clk = ~clk;
	cpc_channel DUT (.CLOCK(clk), .RESET_N(rst_n), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .SLEEP(sleep), .EXT_TICK(ext_tick), .CHANNEL_PIN_IN(pin_in),
		.CHANNEL_PIN_OUT(pin_out), .CHANNEL_PIN_OE_N(oe_n), .IRQ(irq));
	cpc_pin_partner u_pin (.clk(clk), .level(level), .tick_on(tick_on), .pin_out(pin_out),
		.pin_oe_n(oe_n), .pin_in(pin_in), .ext_tick(ext_tick));
	always @(posedge clk)
	begin
		cnt <= cnt + 1;
		pin_d <= pin_out;
		if (pin_out === 1'b1 && pin_d === 1'b0)
		begin
			per_len <= cnt - t_rise;
			t_rise <= cnt;
			rises <= rises + 1;
		end
		if (pin_out === 1'b0 && pin_d === 1'b1)
			hi_len <= cnt - t_rise;
	end
	task automatic results();
		if (num_errors == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// one run-wide bound cuts every wait short
	task automatic step();
		@(posedge clk);
		spin++;
		if (spin > 90000)
		begin
			num_errors++;
			results();
		end
	endtask
	task automatic chk(input string w, input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e)
		begin
			num_errors++;
			$display("unexpected %s expected %h seen %h", w, e, g);
		end
	endtask
	task automatic apb(input logic wr_en, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr_en;
		paddr <= a;
		pwdata <= d;
		step();
		penable <= 1'b1;
		do
			step();
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		step();
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk($sformatf("reg %h", a), rd, e);
	endtask
	task automatic flag(input logic e);
		apb(1'b0, CPC_ADDR_STATUS, 32'h0);
		chk("capture flag", {31'h0, rd[0]}, {31'h0, e});
	endtask
	task automatic pulses(input int k);
		repeat (k)
		begin
			level <= 1'b1;
			repeat (3) step();
			level <= 1'b0;
			repeat (3) step();
		end
	endtask
	task automatic wait_rises(input int k);
		int g;
		g = rises + k;
		while (rises < g)
			step();
	endtask
	initial
	begin
		repeat (3) step();
		rst_n <= 1'b1;
		repeat (3) step();
		rchk(CPC_ADDR_CTRL, 32'h0);
		rchk(CPC_ADDR_PERIOD, 32'hFF);
		apb(1'b0, 8'h20, 32'h0);
		chk("slverr", {31'h0, err}, 32'h1);
		wr(CPC_ADDR_CAP_CFG, 32'h4);
		tick_on <= 1'b1;
		repeat (40) step();
		tick_on <= 1'b0;
		sleep <= 1'b1;
		apb(1'b0, CPC_ADDR_TIMER, 32'h0);
		t = rd;
		wr(CPC_ADDR_MASK, 32'h1);
		for (int md = 4; md < 8; md++)
		begin
			wr(CPC_ADDR_CTRL, 32'h0);
			wr(CPC_ADDR_CTRL, 32'(md));
			wr(CPC_ADDR_STATUS, 32'h3);
			pulses(need[md - 4] - 1);
			flag(1'b0);
			pulses(1);
			flag(1'b1);
			chk("irq", {31'h0, irq}, 32'h1);
			rchk(CPC_ADDR_DUTY_LOW, {24'h0, t[7:0]});
			rchk(CPC_ADDR_DUTY_HIGH, {24'h0, t[15:8]});
		end
		wr(CPC_ADDR_STATUS, 32'h1);
		pulses(8);
		wr(CPC_ADDR_CTRL, 32'h0);
		wr(CPC_ADDR_CTRL, 32'h7);
		pulses(15);
		flag(1'b0);
		pulses(1);
		flag(1'b1);
		wr(CPC_ADDR_MASK, 32'h0);
		chk("irq", {31'h0, irq}, 32'h0);
		wr(CPC_ADDR_STATUS, 32'h1);
		flag(1'b0);
		wr(CPC_ADDR_CAP_CFG, 32'h0);
		apb(1'b0, CPC_ADDR_TIMER, 32'h0);
		t = rd;
		repeat (20) step();
		rchk(CPC_ADDR_TIMER, t);
		sleep <= 1'b0;
		repeat (20) step();
		apb(1'b0, CPC_ADDR_TIMER, 32'h0);
		chk("timer runs", {31'h0, rd !== t}, 32'h1);
		wr(CPC_ADDR_CTRL, 32'h0);
		wr(CPC_ADDR_CTRL, 32'h5);
		wr(CPC_ADDR_STATUS, 32'h1);
		pulses(1);
		apb(1'b0, CPC_ADDR_DUTY_LOW, 32'h0);
		t = rd;
		pulses(1);
		apb(1'b0, CPC_ADDR_DUTY_LOW, 32'h0);
		chk("overwrite", {31'h0, rd !== t}, 32'h1);
		wr(CPC_ADDR_STATUS, 32'h1);
		wr(CPC_ADDR_PERIOD, 32'h4);
		for (int p = 0; p < 2; p++)
		begin
			m = p ? 4 : 1;
			wr(CPC_ADDR_CAP_CFG, 32'(p));
			wr(CPC_ADDR_CTRL, 32'h1C);
			wr(CPC_ADDR_DUTY_LOW, 32'h2);
			wait_rises(3);
			chk("pulse", hi_len, 9 * m);
			chk("period", per_len, 20 * m);
			chk("oe_n", {31'h0, oe_n}, 32'h0);
			rchk(CPC_ADDR_STATUS, 32'h2);
			wr(CPC_ADDR_DUTY_HIGH, 32'hAA);
			rchk(CPC_ADDR_DUTY_HIGH, 32'h2);
		end
		wait_rises(1);
		wr(CPC_ADDR_DUTY_LOW, 32'h1);
		wait_rises(1);
		chk("pulse", hi_len, 36);
		wait_rises(1);
		chk("pulse", hi_len, 20);
		wr(CPC_ADDR_DUTY_LOW, 32'h0);
		wr(CPC_ADDR_CTRL, 32'h0C);
		repeat (100) step();
		r = rises;
		repeat (200) step();
		chk("rises", rises, r);
		results();
	end
endmodule
`default_nettype wire
